//--- hw/ivs_pkg.sv
/*
  Package for the interrupt vector and sleep control block: vector addresses,
  priorities, sleep mode codes, bus carriers and the bootloader key values.
  Assumes a 16-bit address space with vectors at the top of memory.
*/
package ivs_pkg;

  // vector word addresses
  localparam logic [15:0] VEC_RESET      = 16'hfffe;
  localparam logic [15:0] VEC_NMI        = 16'hfffc;
  localparam logic [15:0] VEC_T1_CMP0    = 16'hfffa;
  localparam logic [15:0] VEC_T1_OTHER   = 16'hfff8;
  localparam logic [15:0] VEC_WDT_INTV   = 16'hfff4;
  localparam logic [15:0] VEC_T0_CMP0    = 16'hfff2;
  localparam logic [15:0] VEC_T0_OTHER   = 16'hfff0;
  localparam logic [15:0] VEC_SER_RX     = 16'hffee;
  localparam logic [15:0] VEC_SER_TX     = 16'hffec;
  localparam logic [15:0] VEC_CONV       = 16'hffea;
  localparam logic [15:0] VEC_PORT2      = 16'hffe6;
  localparam logic [15:0] VEC_PORT1      = 16'hffe4;
  localparam logic [15:0] VEC_BSL_KEY    = 16'hffde;
  localparam logic [15:0] VEC_AREA_LO    = 16'hffc0;

  // priorities
  localparam logic [4:0] PRI_RESET    = 5'h1f;
  localparam logic [4:0] PRI_NMI      = 5'h1e;
  localparam logic [4:0] PRI_T1_CMP0  = 5'h1d;
  localparam logic [4:0] PRI_T1_OTHER = 5'h1c;
  localparam logic [4:0] PRI_WDT_INTV = 5'h1a;
  localparam logic [4:0] PRI_T0_CMP0  = 5'h19;
  localparam logic [4:0] PRI_T0_OTHER = 5'h18;
  localparam logic [4:0] PRI_SER_RX   = 5'h17;
  localparam logic [4:0] PRI_SER_TX   = 5'h16;
  localparam logic [4:0] PRI_CONV     = 5'h15;
  localparam logic [4:0] PRI_PORT2    = 5'h13;
  localparam logic [4:0] PRI_PORT1    = 5'h12;

  // register space limit for reset on fetch, erased word and bootloader key values
  localparam logic [15:0] REG_SPACE_HI  = 16'h01ff;
  localparam logic [15:0] ERASED_WORD   = 16'hffff;
  localparam logic [15:0] BSL_DISABLE   = 16'haa55;
  localparam logic [15:0] BSL_NO_ERASE  = 16'h0000;

  // serial modes
  localparam logic [1:0] SER_UART = 2'h0;
  localparam logic [1:0] SER_SPI  = 2'h1;
  localparam logic [1:0] SER_I2C  = 2'h2;

  // sleep mode request codes from the core
  typedef enum logic [2:0] {
    IVS_ACTIVE  = 3'h0,
    IVS_SLEEP_A = 3'h1,
    IVS_SLEEP_B = 3'h3,
    IVS_SLEEP_C = 3'h2,
    IVS_SLEEP_D = 3'h6,
    IVS_SLEEP_E = 3'h7
  } ivs_mode_t;

  // vector fetch sequencer states
  typedef enum logic [1:0] {
    IVS_ST_RUN   = 2'h0,
    IVS_ST_FETCH = 2'h1,
    IVS_ST_HAND  = 2'h3,
    IVS_ST_BOOT  = 2'h2
  } ivs_state_t;

  // clock gates driven out
  typedef struct packed {
    logic cpu_run;
    logic main_clk_en;
    logic sub_main_clk_en;
    logic aux_clk_en;
    logic osc_bias_en;
    logic crystal_en;
  } ivs_clk_t;

  // reset flag bundle
  typedef struct packed {
    logic power_on_flag;
    logic pin_reset_flag;
    logic watchdog_flag;
    logic osc_fault_flag;
  } ivs_rstf_t;

  // reset values of the reset flags
  localparam ivs_rstf_t RSTF_INIT = 4'b1001;

  // selected vector
  typedef struct packed {
    logic        valid;
    logic [4:0]  prio;
    logic [15:0] addr;
  } ivs_vec_t;

endpackage

//--- hw/ivs_prio.sv
/*
  Priority picker: chooses the highest-priority pending request and gives its
  vector address. Assumes request vector sorted by priority, bit 0 lowest.
*/
`timescale 1ns/10ps
module ivs_prio
  import ivs_pkg::*;
#(
  parameter int N = 12
) (
  input  wire logic [N-1:0]       req,
  input  wire logic [N*16-1:0]    addrs,
  input  wire logic [N*5-1:0]     prios,
  output ivs_vec_t                pick
);

  // scan upward so the last (highest) set bit wins
  always_comb begin
    pick = '0;
    for (int i = 0; i < N; i++) begin
      if (req[i]) begin
        pick.valid = 1'b1;
        pick.addr  = addrs[i*16 +: 16];
        pick.prio  = prios[i*5 +: 5];
      end
    end
  end

endmodule

//--- hw/ivs_top.sv
/*
  Interrupt vectoring and sleep control for a small 16-bit core.
  Collects reset, non-maskable and maskable requests, picks the highest
  priority, fetches its vector word and gates clocks per sleep mode.
  Assumes request inputs are synchronous to core_clk, one-cycle ack from core.
*/
// How it works
// - any interrupt wakes; sleep mode restored after return
// - active operation keeps every clock running
// - level a: cpu, main clock stop
// - level b: also bias off if unused
// - level c: main, sub-main off, bias on
// - level d: only auxiliary clock left running
// - deepest: all clocks, bias, crystal stopped
// - vectors at top words hold handler address
// - erased reset vector forces deepest sleep
// - all reset sources share top vector
// - fetch from register or unused space resets
// - non-maskable group: own enables, ignores global
// - timer and watchdog vectors at fixed priorities
// - serial, converter, port vectors fixed priorities
// - receive vector flags depend on serial mode
// - transmit vector flags depend on serial mode
// - bootloader key disables loader or erase
// - lowest vector range left for program code
// - power-on, osc fault flags set after reset
`timescale 1ns/10ps
module ivs_top
  import ivs_pkg::*;
#(
  parameter bit HAS_CONV  = 1'b1,
  parameter int CODE_LO   = 16'hc000
) (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  // reset causes
  input  wire logic        pin_reset_evt,
  input  wire logic        watchdog_evt,
  input  wire logic        flash_key_violation_flag,
  input  wire logic        rst_flag_clr,
  // fetch address watch
  input  wire logic        fetch_valid,
  input  wire logic [15:0] fetch_addr,
  // non-maskable group
  input  wire logic        pin_nmi_flag,
  input  wire logic        osc_fault_evt,
  input  wire logic        flash_access_violation_flag,
  input  wire logic        nmi_en,
  input  wire logic        osc_fault_en,
  input  wire logic        acc_viol_en,
  // maskable sources (flag and enable already combined by peripheral)
  input  wire logic        t1_compare_event_flag,
  input  wire logic        t1_other_flags,
  input  wire logic        wdt_interval_flag,
  input  wire logic        t0_compare_event_flag,
  input  wire logic        t0_other_flags,
  input  wire logic [1:0]  serial_b_mode,
  input  wire logic        serial_a_rx_flag,
  input  wire logic        serial_a_tx_flag,
  input  wire logic        serial_b_rx_flag,
  input  wire logic        serial_b_tx_flag,
  input  wire logic        arbitration_lost_flag,
  input  wire logic        not_ack_flag,
  input  wire logic        start_seen_flag,
  input  wire logic        stop_seen_flag,
  input  wire logic        converter_done_flag,
  input  wire logic [7:0]  port2_edge_flags,
  input  wire logic [7:0]  port1_edge_flags,
  input  wire logic        global_int_en,
  // core side
  input  ivs_mode_t        sleep_req,
  input  wire logic        dco_used_active,
  input  wire logic        int_ack,
  input  wire logic        int_return,
  // vector programming
  input  wire logic        vec_wr_en,
  input  wire logic [4:0]  vec_wr_idx,
  input  wire logic [15:0] vec_wr_data,
  // outputs
  output logic             core_reset,
  output logic             int_pending,
  output logic [15:0]      vec_addr,
  output logic [15:0]      vec_data,
  output logic             vec_ready,
  output logic [4:0]       vec_prio,
  output ivs_clk_t         clk_ctl,
  output ivs_mode_t        mode_now,
  output ivs_rstf_t        rst_flags,
  output logic             bsl_disabled,
  output logic             bsl_no_erase
);

  localparam int NREQ = 12;

  ////////////////////////////////////////////////////////////////////////////
  // state

  ivs_state_t  state;
  ivs_state_t  next_state;
  ivs_mode_t   saved_mode;
  ivs_mode_t   cur_mode;
  ivs_mode_t   next_mode;
  logic        data_ok;
  logic        bad_fetch;
  logic        reset_hold;
  logic [15:0] rom_q;
  logic [4:0]  rom_idx;
  logic [15:0] key_word;
  ivs_vec_t    pick;

  ////////////////////////////////////////////////////////////////////////////
  // address helpers

  // word index into the vector area
  function automatic logic [4:0] vec_index(input logic [15:0] a);
    logic [15:0] d;
    d = a - VEC_AREA_LO;
    return d[5:1];
  endfunction

  // outside code, info, ram and vector area is unused
  function automatic logic unused_space(input logic [15:0] a);
    return (a <= REG_SPACE_HI)
      || (a > 16'h03ff && a < 16'h1000)
      || (a > 16'h10ff && a < CODE_LO[15:0]);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // request collection

  wire rx_group = (serial_b_mode == SER_I2C) ?
                  (arbitration_lost_flag | not_ack_flag | start_seen_flag | stop_seen_flag) :
                  (serial_a_rx_flag | (serial_b_mode == SER_SPI && serial_b_rx_flag));
  wire tx_group = (serial_b_mode == SER_I2C) ?
                  (serial_a_tx_flag | serial_b_rx_flag | serial_b_tx_flag) :
                  (serial_a_tx_flag | serial_b_tx_flag);

  // non-maskable ignores the global enable
  wire nmi_req = (pin_nmi_flag & nmi_en) | (rst_flags.osc_fault_flag & osc_fault_en)
               | (flash_access_violation_flag & acc_viol_en);
  wire gie     = global_int_en;

  // requests sorted lowest priority first; reset handled separately
  wire [NREQ-1:0] req = {
    nmi_req,
    gie & t1_compare_event_flag,
    gie & t1_other_flags,
    gie & wdt_interval_flag,
    gie & t0_compare_event_flag,
    gie & t0_other_flags,
    gie & rx_group,
    gie & tx_group,
    gie & HAS_CONV & converter_done_flag,
    gie & (|port2_edge_flags),
    gie & (|port1_edge_flags),
    1'b0
  };
  // nothing below priority 18 is requested, lowest range free for code
  wire [NREQ*16-1:0] addrs = {VEC_NMI, VEC_T1_CMP0, VEC_T1_OTHER, VEC_WDT_INTV,
                              VEC_T0_CMP0, VEC_T0_OTHER, VEC_SER_RX, VEC_SER_TX,
                              VEC_CONV, VEC_PORT2, VEC_PORT1, VEC_RESET};
  wire [NREQ*5-1:0]  prios = {PRI_NMI, PRI_T1_CMP0, PRI_T1_OTHER, PRI_WDT_INTV,
                              PRI_T0_CMP0, PRI_T0_OTHER, PRI_SER_RX, PRI_SER_TX,
                              PRI_CONV, PRI_PORT2, PRI_PORT1, PRI_RESET};

  ivs_prio #(
    .N     (NREQ)
  ) u_prio (
    .req   (req),
    .addrs (addrs),
    .prios (prios),
    .pick  (pick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // vector memory

  wire [4:0] pick_idx = vec_index(pick.addr);
  assign rom_idx = (state == IVS_ST_BOOT || reset_hold) ? vec_index(VEC_RESET) : pick_idx;

  ivs_vecrom #(
    .DEPTH   (32)
  ) u_rom (
    .core_clk(core_clk),
    .wr_en   (vec_wr_en),
    .wr_idx  (vec_wr_idx),
    .wr_data (vec_wr_data),
    .rd_idx  (rom_idx),
    .rd_data (rom_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // reset sources

  // every reset cause funnels into the single top vector
  assign bad_fetch = fetch_valid & unused_space(fetch_addr);
  wire   any_reset = pin_reset_evt | watchdog_evt | flash_key_violation_flag | bad_fetch;

  // flags: hardware set beats software clear
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rst_flags <= RSTF_INIT;
    end else begin
      if (rst_flag_clr) rst_flags <= '0;
      if (pin_reset_evt) rst_flags.pin_reset_flag <= 1'b1;
      if (watchdog_evt | flash_key_violation_flag) rst_flags.watchdog_flag <= 1'b1;
      if (osc_fault_evt) rst_flags.osc_fault_flag <= 1'b1;
    end
  end

  // internal reset held one cycle, then boot sequence refetches
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reset_hold <= 1'b1;
    end else begin
      reset_hold <= any_reset;
    end
  end
  assign core_reset = reset_hold;

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  // boot reads the reset vector; erased word means sleep at once
  always_comb begin
    next_state = state;
    next_mode  = cur_mode;
    case (state)
      IVS_ST_BOOT: begin
        if (!reset_hold) begin
          next_state = IVS_ST_RUN;
          next_mode  = (rom_q == ERASED_WORD) ? IVS_SLEEP_E : IVS_ACTIVE;
        end
      end
      IVS_ST_RUN: begin
        if (pick.valid) begin
          next_state = IVS_ST_FETCH;
          next_mode  = IVS_ACTIVE;
        end else begin
          next_mode  = (cur_mode == IVS_ACTIVE || sleep_req == IVS_ACTIVE) ? sleep_req : cur_mode;
        end
      end
      IVS_ST_FETCH: begin
        if (int_ack && data_ok) begin
          next_state = IVS_ST_HAND;
        end
      end
      IVS_ST_HAND: begin
        if (int_return) begin
          next_state = IVS_ST_RUN;
          next_mode  = saved_mode;
        end
      end
      default: begin
        next_state = IVS_ST_BOOT;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= IVS_ST_BOOT;
      cur_mode <= IVS_ACTIVE;
      saved_mode <= IVS_ACTIVE;
      data_ok <= 1'b0;
    end else if (reset_hold) begin
      state <= IVS_ST_BOOT;
      cur_mode <= IVS_ACTIVE;
      data_ok <= 1'b0;
    end else begin
      state <= next_state;
      cur_mode <= next_mode;
      if (state == IVS_ST_RUN && pick.valid) saved_mode <= cur_mode;
      data_ok <= (state == IVS_ST_FETCH) && (next_state == IVS_ST_FETCH); // word loaded
    end
  end

  // vector outputs from flops
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      vec_addr <= '0;
      vec_prio <= '0;
      vec_data <= '0;
      key_word <= '0;
    end else begin
      if (state == IVS_ST_RUN && pick.valid) begin
        vec_addr <= pick.addr;
        vec_prio <= pick.prio;
      end
      if (state == IVS_ST_FETCH && !data_ok) vec_data <= rom_q;
      if (vec_wr_en && vec_wr_idx == vec_index(VEC_BSL_KEY)) key_word <= vec_wr_data;
    end
  end

  assign int_pending = (state == IVS_ST_FETCH);
  // offered only once the word has landed, so an ack never takes a stale vector
  assign vec_ready   = (state == IVS_ST_FETCH) && data_ok;
  assign mode_now    = cur_mode;

  // bootloader key decode
  assign bsl_disabled = (key_word == BSL_DISABLE);
  assign bsl_no_erase = (key_word == BSL_NO_ERASE);

  ////////////////////////////////////////////////////////////////////////////
  // clock gating per mode

  wire sleeping = (cur_mode != IVS_ACTIVE);
  always_comb begin
    clk_ctl = '1;
    case (cur_mode)
      IVS_SLEEP_A: begin
        clk_ctl.cpu_run     = 1'b0;
        clk_ctl.main_clk_en = 1'b0;
      end
      IVS_SLEEP_B: begin
        clk_ctl.cpu_run     = 1'b0;
        clk_ctl.main_clk_en = 1'b0;
        clk_ctl.osc_bias_en = dco_used_active;
      end
      IVS_SLEEP_C: begin
        clk_ctl.cpu_run         = 1'b0;
        clk_ctl.main_clk_en     = 1'b0;
        clk_ctl.sub_main_clk_en = 1'b0;
      end
      IVS_SLEEP_D: begin
        clk_ctl.cpu_run         = 1'b0;
        clk_ctl.main_clk_en     = 1'b0;
        clk_ctl.sub_main_clk_en = 1'b0;
        clk_ctl.osc_bias_en     = 1'b0;
      end
      IVS_SLEEP_E: begin
        clk_ctl = '0;
      end
      default: begin
        clk_ctl.cpu_run = ~sleeping;
      end
    endcase
  end

endmodule

//--- hw/ivs_vecrom.sv
/*
  Vector memory: holds the 32 vector words at the top of memory, written by
  the programming path, read through a registered port.
  Assumes word index = (address - lowest vector address) / 2.
*/
`timescale 1ns/10ps
module ivs_vecrom
  import ivs_pkg::*;
#(
  parameter int DEPTH = 32
) (
  input  wire logic                     core_clk,
  input  wire logic                     wr_en,
  input  wire logic [$clog2(DEPTH)-1:0] wr_idx,
  input  wire logic [15:0]              wr_data,
  input  wire logic [$clog2(DEPTH)-1:0] rd_idx,
  output logic      [15:0]              rd_data
);

  logic [15:0] mem [DEPTH];

  // erased flash content at power-up, so an empty part sleeps
  initial begin
    for (int i = 0; i < DEPTH; i++) begin
      mem[i] = ERASED_WORD;
    end
  end

  // one write port, registered read
  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
    rd_data <= mem[rd_idx];
  end

endmodule

//--- verif/interrupt_vector_and_sleep_control_test.sv
/*
  Self-checking bench for ivs_top: boot, key word, sleep modes, vectors,
  masking, serial modes, wake-up and reset causes.
  Assumes the vector memory starts erased; inputs change at falling edges.
*/
`timescale 1ns/10ps
module interrupt_vector_and_sleep_control_test;
  import ivs_pkg::*;
  logic        core_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        pin_reset_evt = 1'b0, watchdog_evt = 1'b0, rst_flag_clr = 1'b0, fetch_valid = 1'b0;
  logic [15:0] fetch_addr = 16'hc000;
  logic [10:0] src = '0;
  logic [3:0]  i2c_st = '0;
  logic        sb_rx = 1'b0, sb_tx = 1'b0, nmi_en = 1'b1, gie = 1'b1, dco_used = 1'b0, slow = 1'b0, key_viol = 1'b0;
  logic [1:0]  sb_mode = SER_UART;
  logic        vec_wr_en = 1'b0;
  logic [4:0]  vec_wr_idx = '0;
  logic [15:0] vec_wr_data = '0;
  ivs_mode_t   sleep_req = IVS_SLEEP_A;
  wire         int_ack, int_return, core_reset, int_pending, vec_ready, bsl_disabled, bsl_no_erase;
  wire [15:0]  vec_addr, vec_data;
  wire [4:0]   vec_prio;
  ivs_clk_t    clk_ctl;
  ivs_mode_t   mode_now;
  ivs_rstf_t   rst_flags;
  int          bad_count = 0;
  int          checks_done = 0;
  int          prio_tab[11] = '{18, 19, 21, 22, 23, 24, 25, 26, 28, 29, 30};

  // 20 MHz clock
  always #25 core_clk = ~core_clk;

  ////////////////////////////////////////////////////////////////////////
  // src bits, lowest priority first; port bits chosen apart to test the OR
  ivs_top u_dut (.core_clk, .sys_rst, .pin_reset_evt, .watchdog_evt, .flash_key_violation_flag(key_viol),
    .rst_flag_clr, .fetch_valid, .fetch_addr, .pin_nmi_flag(src[10]), .osc_fault_evt(1'b0),
    .flash_access_violation_flag(1'b0), .nmi_en, .osc_fault_en(1'b0), .acc_viol_en(1'b0),
    .t1_compare_event_flag(src[9]), .t1_other_flags(src[8]), .wdt_interval_flag(src[7]),
    .t0_compare_event_flag(src[6]), .t0_other_flags(src[5]), .serial_b_mode(sb_mode),
    .serial_a_rx_flag(src[4]), .serial_a_tx_flag(src[3]), .serial_b_rx_flag(sb_rx),
    .serial_b_tx_flag(sb_tx), .arbitration_lost_flag(i2c_st[0]), .not_ack_flag(i2c_st[1]),
    .start_seen_flag(i2c_st[2]), .stop_seen_flag(i2c_st[3]), .converter_done_flag(src[2]),
    .port2_edge_flags({7'h00, src[1]}), .port1_edge_flags({src[0], 7'h00}), .global_int_en(gie),
    .sleep_req, .dco_used_active(dco_used), .int_ack, .int_return, .vec_wr_en, .vec_wr_idx,
    .vec_wr_data, .core_reset, .int_pending, .vec_addr, .vec_data, .vec_ready, .vec_prio, .clk_ctl,
    .mode_now, .rst_flags, .bsl_disabled, .bsl_no_erase);

  ivs_core_model u_core (.core_clk, .sys_rst, .vec_ready, .slow, .int_ack, .int_return);

  ////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("checks=%0d mismatches=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  // caller lowers vec_wr_en after its last word
  task automatic vwr(input logic [4:0] idx, input logic [15:0] d);
    vec_wr_idx = idx;
    vec_wr_data = d;
    vec_wr_en = 1'b1;
    cyc(1);
  endtask

  function automatic logic [5:0] clk_exp(input ivs_mode_t m, input logic d);
    case (m)
      IVS_ACTIVE:  return 6'h3f;
      IVS_SLEEP_A: return 6'h0f;
      IVS_SLEEP_B: return {4'h3, d, 1'b1};
      IVS_SLEEP_C: return 6'h07;
      IVS_SLEEP_D: return 6'h05;
      default:     return 6'h00;
    endcase
  endfunction

  // wait for the offer, judge it, let the core take it, then drop sources
  task automatic serve(input int p);
    int n;
    n = 0;
    while (vec_ready !== 1'b1 && n < 40) begin
      cyc(1);
      n++;
    end
    chk(n < 40, 1'b1);
    chk(vec_prio, p);
    chk(vec_addr, 16'hffc0 + 2 * p);
    chk(vec_data, 16'hc100 + 4 * p);
    chk(clk_ctl.cpu_run, 1'b1);
    if (n == 40) close_out();
    n = 0;
    while (vec_ready === 1'b1 && n < 40) begin
      cyc(1);
      n++;
    end
    src = '0;
    i2c_st = '0;
    sb_rx = 1'b0;
    sb_tx = 1'b0;
    cyc(8);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_modes();
    ivs_mode_t mt[6] = '{IVS_SLEEP_A, IVS_SLEEP_B, IVS_SLEEP_B, IVS_SLEEP_C, IVS_SLEEP_D, IVS_SLEEP_E};
    for (int i = 0; i < 6; i++) begin
      dco_used = (i == 2);
      sleep_req = mt[i];
      cyc(3);
      chk(mode_now, mt[i]);
      chk(clk_ctl, clk_exp(mt[i], dco_used));
      sleep_req = IVS_ACTIVE;
      cyc(3);
      chk(clk_ctl, 6'h3f);
    end
  endtask

  task automatic t_irq();
    for (int i = 0; i < 11; i++) begin
      slow = i[0];
      src[i] = 1'b1;
      serve(prio_tab[i]);
    end
    src = 11'h201;
    serve(29);
    gie = 1'b0;
    src[0] = 1'b1;
    cyc(6);
    chk(int_pending, 1'b0);
    src[10] = 1'b1;
    serve(30);
    nmi_en = 1'b0;
    src[10] = 1'b1;
    cyc(6);
    chk(int_pending, 1'b0);
    src = '0;
    nmi_en = 1'b1;
    gie = 1'b1;
    cyc(2);
  endtask

  task automatic t_serial();
    sb_mode = SER_SPI;
    sb_rx = 1'b1;
    serve(23);
    sb_tx = 1'b1;
    serve(22);
    sb_mode = SER_I2C;
    for (int k = 0; k < 4; k++) begin
      i2c_st[k] = 1'b1;
      serve(23);
    end
    sb_rx = 1'b1;
    serve(22);
    sb_tx = 1'b1;
    serve(22);
    sb_mode = SER_UART;
    sb_tx = 1'b1;
    serve(22);
  endtask

  // wake from a sleep level, then the level comes back after return
  task automatic t_wake();
    ivs_mode_t wm[2] = '{IVS_SLEEP_C, IVS_SLEEP_E};
    for (int i = 0; i < 2; i++) begin
      sleep_req = wm[i];
      cyc(3);
      src[1] = 1'b1;
      serve(19);
      chk(mode_now, wm[i]);
      sleep_req = IVS_ACTIVE;
      cyc(3);
    end
  endtask

  task automatic t_resets();
    logic [15:0] fa[4] = '{16'h0000, 16'h01ff, 16'h0500, 16'hc000};
    pin_reset_evt = 1'b1;
    cyc(1);
    pin_reset_evt = 1'b0;
    chk({core_reset, rst_flags.pin_reset_flag}, 2'b11);
    cyc(6);
    watchdog_evt = 1'b1;
    cyc(1);
    watchdog_evt = 1'b0;
    chk({core_reset, rst_flags.watchdog_flag}, 2'b11);
    cyc(6);
    rst_flag_clr = 1'b1;
    cyc(1);
    rst_flag_clr = 1'b0;
    chk(rst_flags, 4'h0);
    key_viol = 1'b1;
    cyc(1);
    key_viol = 1'b0;
    chk({core_reset, rst_flags.watchdog_flag, rst_flags.pin_reset_flag}, 3'b110);
    cyc(6);
    for (int i = 0; i < 4; i++) begin
      fetch_valid = 1'b1;
      fetch_addr = fa[i];
      cyc(1);
      fetch_valid = 1'b0;
      chk(core_reset, i < 3);
      cyc(6);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // main sequence; erased boot first, then program the vector words
  initial begin
    cyc(10);
    sys_rst = 1'b0;
    cyc(5);
    chk(mode_now, IVS_SLEEP_E);
    chk(clk_ctl, 6'h00);
    chk(rst_flags, 4'h9);
    chk({bsl_disabled, bsl_no_erase}, 2'b01);
    for (int p = 18; p < 31; p++) vwr(p[4:0], 16'(16'hc100 + 4 * p));
    vwr(5'h1f, 16'hc000);
    vwr(5'h0f, BSL_DISABLE);
    vec_wr_en = 1'b0;
    cyc(2);
    chk({bsl_disabled, bsl_no_erase}, 2'b10);
    vwr(5'h0f, 16'h0000);
    vec_wr_en = 1'b0;
    cyc(2);
    chk({bsl_disabled, bsl_no_erase}, 2'b01);
    sleep_req = IVS_ACTIVE;
    cyc(3);
    chk(mode_now, IVS_ACTIVE);
    t_modes();
    t_irq();
    t_serial();
    t_wake();
    t_resets();
    close_out();
  end

  // hang guard
  initial begin
    #1000000;
    bad_count++;
    close_out();
  end
endmodule

//--- verif/ivs_core_model.sv
/*
  Behavioural core: takes an offered vector, acks it, runs a short
  handler and returns. Assumes vec_ready stands until the ack edge.
*/
`timescale 1ns/10ps
module ivs_core_model
  import ivs_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic vec_ready,
  input wire logic slow,
  output logic     int_ack,
  output logic     int_return
);
  int wait_cnt;
  int ret_cnt;

  // ack after 0 or 3 idle cycles, return 4 cycles after the ack
  always @(negedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      int_ack    <= 1'b0;
      int_return <= 1'b0;
      wait_cnt   <= 0;
      ret_cnt    <= 0;
    end else begin
      int_ack    <= 1'b0;
      int_return <= 1'b0;
      if (ret_cnt > 0) begin
        ret_cnt <= ret_cnt - 1;
        int_return <= (ret_cnt == 1);
      end else if (vec_ready && !int_ack) begin
        if (wait_cnt >= (slow ? 3 : 0)) begin
          int_ack  <= 1'b1;
          ret_cnt  <= 4;
          wait_cnt <= 0;
        end else begin
          wait_cnt <= wait_cnt + 1;
        end
      end
    end
  end
endmodule

//--- verif/ivs_top_sva.sv
/*
  Checker for the vector and sleep control block: clock gating per mode,
  reset causes, vector hand-off and bootloader key decode.
  Assumes it is bound to ivs_top and sees only its ports.
*/
`timescale 1ns/10ps
module ivs_top_sva
  import ivs_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        sys_rst,
  input wire logic        pin_reset_evt,
  input wire logic        fetch_valid,
  input wire logic [15:0] fetch_addr,
  input wire logic        dco_used_active,
  input wire logic        vec_wr_en,
  input wire logic [4:0]  vec_wr_idx,
  input wire logic [15:0] vec_wr_data,
  input wire logic        int_ack,
  input wire logic        core_reset,
  input wire logic        vec_ready,
  input wire logic [15:0] vec_addr,
  input wire ivs_clk_t    clk_ctl,
  input wire ivs_mode_t   mode_now,
  input wire ivs_rstf_t   rst_flags,
  input wire logic        bsl_disabled,
  input wire logic        bsl_no_erase
);
  // one domain, so one clock and one disable for all
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  ////////////////////////////////////////////////////////////////////////
  // reset causes
  a_pin_reset: assert property (pin_reset_evt |=> core_reset)
    else $error("core reset missing after pin reset");
  a_fetch_reset: assert property (fetch_valid && fetch_addr <= 16'h01ff |=> core_reset)
    else $error("core reset missing after low fetch");
  a_por_flags: assert property ($fell(sys_rst) |-> rst_flags.power_on_flag && rst_flags.osc_fault_flag
    && !rst_flags.pin_reset_flag && !rst_flags.watchdog_flag)
    else $error("reset flags wrong after power up");

  ////////////////////////////////////////////////////////////////////////
  // clock gates follow the held mode
  a_active_clk: assert property (mode_now == IVS_ACTIVE |-> clk_ctl == 6'h3f)
    else $error("active mode gates wrong");
  a_level_a: assert property (mode_now == IVS_SLEEP_A |-> clk_ctl == 6'h0f)
    else $error("level a gates wrong");
  a_level_b: assert property (mode_now == IVS_SLEEP_B |-> clk_ctl == {4'h3, dco_used_active, 1'b1})
    else $error("level b gates wrong");
  a_level_c: assert property (mode_now == IVS_SLEEP_C |-> clk_ctl == 6'h07)
    else $error("level c gates wrong");
  a_level_d: assert property (mode_now == IVS_SLEEP_D |-> clk_ctl == 6'h05)
    else $error("level d gates wrong");
  a_deepest_off: assert property (mode_now == IVS_SLEEP_E |-> clk_ctl == 6'h00)
    else $error("deepest mode gates wrong");

  ////////////////////////////////////////////////////////////////////////
  // vector hand-off: held until taken, core running, top range only
  a_ready_hold: assert property (vec_ready && !int_ack |=> vec_ready && $stable(vec_addr))
    else $error("vector dropped before ack");
  a_wake_top: assert property (vec_ready |-> clk_ctl.cpu_run && vec_addr >= 16'hffe0)
    else $error("vector offered while halted or out of range");
  a_bsl_key: assert property (vec_wr_en && vec_wr_idx == 5'h0f |=>
    bsl_disabled == ($past(vec_wr_data) == BSL_DISABLE) && bsl_no_erase == ($past(vec_wr_data) == BSL_NO_ERASE))
    else $error("key word decode wrong");
endmodule

bind ivs_top ivs_top_sva u_sva (.core_clk, .sys_rst, .pin_reset_evt, .fetch_valid, .fetch_addr,
  .dco_used_active, .vec_wr_en, .vec_wr_idx, .vec_wr_data,
  .int_ack, .core_reset, .vec_ready, .vec_addr, .clk_ctl, .mode_now, .rst_flags,
  .bsl_disabled, .bsl_no_erase);
